//--- slpa_defs.vh
// Contract
// - reset: output low, irqs low, bus released
// - serial output idles low
// - data packet: 1, 1, eight bits, 0
// - data bits go least significant first
// - sender waits for 1,0 acknowledge
// - acknowledge only when another byte fits
// - rate select low 10, high 20 Mbit/s
// - receiver oversamples, independent of clock phase
// - bus driven only when selected and reading
// - select and direction latched at select fall
// - write data taken at select rise
// - four registers decoded by select and direction
// - received byte holds last data, never acks
// - received byte valid only while present flag
// - writes to received byte do nothing
// - receive irq within 14 bit times
// - ack starts 0.8 to 2.5 bits after deselect; here it waits behind a data packet already being sent
// - data read clears flag, irq, sends ack
// - output write clears ready until ack back
// - irq equals enable and flag
// - status: flag bit 0, enable bit 1
`ifndef SLPA_DEFS_VH
`define SLPA_DEFS_VH
`define SLPA_REG_RX_DATA 2'h0
`define SLPA_REG_TX_DATA 2'h1
`define SLPA_REG_RX_STAT 2'h2
`define SLPA_REG_TX_STAT 2'h3
`define SLPA_STAT_FLAG 0
`define SLPA_STAT_IEN 1
`define SLPA_CLK_HZ 40000000
`define SLPA_RATE_LO_HZ 10000000
`define SLPA_RATE_HI_HZ 20000000
// clocks per bit at each rate
`define SLPA_BIT_LO (`SLPA_CLK_HZ / `SLPA_RATE_LO_HZ)
`define SLPA_BIT_HI (`SLPA_CLK_HZ / `SLPA_RATE_HI_HZ)
`define SLPA_DATA_BITS 8
`endif

//--- slpa_link_rx.v
`timescale 1ns/10ps
`default_nettype none
`include "slpa_defs.vh"
module slpa_link_rx (
   // clock and reset
   input wire clk_in,
   input wire nrst_in,
   // link
   input wire serial_in,
   input wire rate_hi_in,
   // received packets
   output reg data_stb_out,
   output reg [7:0] data_out,
   output reg ack_stb_out
);
   localparam S_IDLE = 3'b001;
   localparam S_TYPE = 3'b010;
   localparam S_DATA = 3'b100;
   reg [2:0] state_q;
   reg [2:0] cnt_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   reg sync1_q;
   reg sync2_q;
   wire [2:0] full_w;
   wire [2:0] half_w;
   localparam integer BIT_LO = `SLPA_BIT_LO;
   localparam integer BIT_HI = `SLPA_BIT_HI;
   wire [31:0] bit_lo_w;
   wire [31:0] bit_hi_w;
   assign bit_lo_w = BIT_LO;
   assign bit_hi_w = BIT_HI;
   // link is asynchronous: two-stage sync, then count from the edge
   assign full_w = rate_hi_in ? bit_hi_w[2:0] : bit_lo_w[2:0];
   assign half_w = rate_hi_in ? 3'd2 : 3'd3;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         state_q <= S_IDLE;
         cnt_q <= 3'h0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         data_out <= 8'h00;
         data_stb_out <= 1'b0;
         ack_stb_out <= 1'b0;
      end else begin
         sync1_q <= serial_in;
         sync2_q <= sync1_q;
         data_stb_out <= 1'b0;
         ack_stb_out <= 1'b0;
         case (state_q)
            S_IDLE: begin
               // start edge; next sample lands mid second bit
               if (sync2_q) begin
                  state_q <= S_TYPE;
                  cnt_q <= full_w + half_w - 3'd2;
               end
            end
            S_TYPE: begin
               if (cnt_q == 3'h0) begin
                  if (sync2_q) begin
                     state_q <= S_DATA;
                     bit_q <= 4'h0;
                     cnt_q <= full_w - 3'd1;
                  end else begin
                     ack_stb_out <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end else begin
                  cnt_q <= cnt_q - 3'd1;
               end
            end
            S_DATA: begin
               if (cnt_q == 3'h0) begin
                  cnt_q <= full_w - 3'd1;
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'd`SLPA_DATA_BITS) begin
                     // stop bit slot: wait for line low before idle
                     if (!sync2_q) begin
                        state_q <= S_IDLE;
                     end
                  end else begin
                     shift_q <= {sync2_q, shift_q[7:1]};
                     if (bit_q == 4'd7) begin
                        data_out <= {sync2_q, shift_q[7:1]};
                        data_stb_out <= 1'b1;
                     end
                  end
               end else begin
                  cnt_q <= cnt_q - 3'd1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- slpa_top.v
`timescale 1ns/10ps
`default_nettype none
`include "slpa_defs.vh"
module slpa_top (
   // clock and reset
   input wire clk_in,
   input wire nrst_in,
   // link
   input wire serial_in,
   output reg serial_out,
   input wire rate_select_in,
   // host bus
   input wire select_n_in,
   input wire read_write_n_in,
   input wire [1:0] reg_sel_in,
   input wire [7:0] host_bus_in,
   output reg [7:0] host_bus_out,
   output wire host_bus_oe_n_out,
   // interrupts
   output wire rx_irq_out,
   output wire tx_irq_out
);
   // =====================================================
   // host access capture
   // =====================================================
   reg sel_d1_q;
   reg [1:0] acc_sel_q;
   reg acc_rd_q;
   reg rd_data_done_q;
   wire cs_fall_w;
   wire cs_rise_w;
   assign cs_fall_w = sel_d1_q & ~select_n_in;
   assign cs_rise_w = ~sel_d1_q & select_n_in;
   assign host_bus_oe_n_out = ~(~select_n_in & acc_rd_q & ~sel_d1_q);
   reg rx_flag_q;
   reg rx_ien_q;
   reg tx_ready_q;
   reg tx_ien_q;
   reg [7:0] rx_byte_q;
   reg [7:0] tx_byte_q;
   reg tx_start_q;
   reg ack_req_q;
   wire rx_stb_w;
   wire ack_in_w;
   wire [7:0] rx_data_w;
   wire tx_done_w;
   slpa_link_rx u_rx (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .serial_in(serial_in),
      .rate_hi_in(rate_select_in),
      .data_stb_out(rx_stb_w),
      .data_out(rx_data_w),
      .ack_stb_out(ack_in_w)
   );
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sel_d1_q <= 1'b1;
         acc_sel_q <= 2'h0;
         acc_rd_q <= 1'b0;
         host_bus_out <= 8'h00;
      end else begin
         sel_d1_q <= select_n_in;
         if (cs_fall_w) begin
            acc_sel_q <= reg_sel_in;
            acc_rd_q <= read_write_n_in;
            // read data for the whole strobe
            if (reg_sel_in == `SLPA_REG_RX_DATA) begin
               host_bus_out <= rx_byte_q;
            end else if (reg_sel_in == `SLPA_REG_RX_STAT) begin
               host_bus_out <= {6'h00, rx_ien_q, rx_flag_q};
            end else if (reg_sel_in == `SLPA_REG_TX_STAT) begin
               host_bus_out <= {6'h00, tx_ien_q, tx_ready_q};
            end else begin
               host_bus_out <= 8'h00;
            end
         end
         if (cs_rise_w) begin
            acc_rd_q <= 1'b0;
         end
      end
   end
   // =====================================================
   // status, enables and data registers
   // =====================================================
   wire rd_rx_w;
   wire wr_tx_w;
   wire wr_rxs_w;
   wire wr_txs_w;
   assign rd_rx_w = cs_fall_w & read_write_n_in &
      (reg_sel_in == `SLPA_REG_RX_DATA);
   assign wr_tx_w = cs_rise_w & ~acc_rd_q &
      (acc_sel_q == `SLPA_REG_TX_DATA);
   assign wr_rxs_w = cs_rise_w & ~acc_rd_q &
      (acc_sel_q == `SLPA_REG_RX_STAT);
   assign wr_txs_w = cs_rise_w & ~acc_rd_q &
      (acc_sel_q == `SLPA_REG_TX_STAT);
   // write to received byte decodes to nothing
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_flag_q <= 1'b0;
         rx_ien_q <= 1'b0;
         tx_ien_q <= 1'b0;
         tx_ready_q <= 1'b1;
         rx_byte_q <= 8'h00;
         tx_byte_q <= 8'h00;
         tx_start_q <= 1'b0;
         rd_data_done_q <= 1'b0;
      end else begin
         tx_start_q <= 1'b0;
         if (rx_stb_w) begin
            rx_byte_q <= rx_data_w;
            rx_flag_q <= 1'b1;
         end else if (rd_rx_w) begin
            rx_flag_q <= 1'b0;
         end
         if (rd_rx_w) begin
            rd_data_done_q <= 1'b1;
         end else if (cs_rise_w) begin
            rd_data_done_q <= 1'b0;
         end
         if (wr_rxs_w) begin
            rx_ien_q <= host_bus_in[`SLPA_STAT_IEN];
         end
         if (wr_txs_w) begin
            tx_ien_q <= host_bus_in[`SLPA_STAT_IEN];
         end
         if (wr_tx_w) begin
            tx_byte_q <= host_bus_in;
            tx_ready_q <= 1'b0;
            tx_start_q <= 1'b1;
         end else if (tx_done_w) begin
            tx_ready_q <= 1'b1;
         end
      end
   end
   assign rx_irq_out = rx_ien_q & rx_flag_q;
   assign tx_irq_out = tx_ien_q & tx_ready_q;
   // =====================================================
   // transmitter: data packets and acknowledges
   // =====================================================
   localparam T_IDLE = 4'b0001;
   localparam T_SEND = 4'b0010;
   localparam T_WAIT = 4'b0100;
   localparam T_ACK = 4'b1000;
   reg [3:0] tstate_q;
   reg [3:0] nbits_q;
   reg [10:0] tshift_q;
   reg [2:0] tcnt_q;
   reg data_pend_q;
   reg is_data_q;
   reg got_ack_q;
   wire bit_end_w;
   wire [2:0] full_w;
   reg ack_dly_q;
   localparam integer BIT_LO = `SLPA_BIT_LO;
   localparam integer BIT_HI = `SLPA_BIT_HI;
   wire [31:0] bit_lo_w;
   wire [31:0] bit_hi_w;
   assign bit_lo_w = BIT_LO;
   assign bit_hi_w = BIT_HI;
   assign full_w = rate_select_in ? bit_hi_w[2:0] : bit_lo_w[2:0];
   assign bit_end_w = (tcnt_q == 3'h0);
   assign tx_done_w = (tstate_q == T_WAIT) & got_ack_q & ~data_pend_q;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tstate_q <= T_IDLE;
         nbits_q <= 4'h0;
         tshift_q <= 11'h000;
         tcnt_q <= 3'h0;
         serial_out <= 1'b0;
         data_pend_q <= 1'b0;
         ack_req_q <= 1'b0;
         is_data_q <= 1'b0;
         got_ack_q <= 1'b0;
         ack_dly_q <= 1'b0;
      end else begin
         if (tx_start_q) begin
            data_pend_q <= 1'b1;
            got_ack_q <= 1'b0;
         end
         if (ack_in_w) begin
            got_ack_q <= 1'b1;
         end
         // ack after deselect of a data read; room for next byte
         // one extra clock keeps the ack at least 0.8 bit after deselect
         ack_dly_q <= cs_rise_w & rd_data_done_q;
         if (ack_dly_q) begin
            ack_req_q <= 1'b1;
         end
         case (tstate_q)
            T_IDLE: begin
               serial_out <= 1'b0;
               // ack first: it frees the peer, bounds delay
               if (ack_req_q) begin
                  ack_req_q <= 1'b0;
                  tshift_q <= 11'h001;
                  nbits_q <= 4'd2;
                  is_data_q <= 1'b0;
                  tstate_q <= T_SEND;
               end else if (data_pend_q) begin
                  data_pend_q <= 1'b0;
                  // start, one, data lsb first, stop
                  tshift_q <= {1'b0, tx_byte_q, 2'b11};
                  nbits_q <= 4'd11;
                  is_data_q <= 1'b1;
                  tstate_q <= T_SEND;
               end
               tcnt_q <= full_w - 3'd1;
            end
            T_SEND: begin
               serial_out <= tshift_q[0];
               if (bit_end_w) begin
                  tcnt_q <= full_w - 3'd1;
                  tshift_q <= {1'b0, tshift_q[10:1]};
                  nbits_q <= nbits_q - 4'h1;
                  if (nbits_q == 4'h1) begin
                     tstate_q <= is_data_q ? T_WAIT : T_IDLE;
                     // a data packet still queued must go out from idle
                     if (!is_data_q) begin
                        tstate_q <= (tx_ready_q | data_pend_q) ?
                           T_IDLE : T_WAIT;
                     end
                  end
               end else begin
                  tcnt_q <= tcnt_q - 3'd1;
               end
            end
            T_WAIT: begin
               serial_out <= 1'b0;
               // acks to send still go out while waiting
               if (got_ack_q) begin
                  tstate_q <= T_IDLE;
               end else if (ack_req_q) begin
                  ack_req_q <= 1'b0;
                  tshift_q <= 11'h001;
                  nbits_q <= 4'd2;
                  is_data_q <= 1'b0;
                  tcnt_q <= full_w - 3'd1;
                  tstate_q <= T_SEND;
               end
            end
            default: tstate_q <= T_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- slpa_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// port checks
module slpa_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // link
   input wire logic serial_out,
   input wire logic rate_select_in,
   // host side
   input wire logic select_n_in,
   input wire logic read_write_n_in,
   input wire logic [1:0] reg_sel_in,
   input wire logic [7:0] host_bus_out,
   input wire logic host_bus_oe_n_out,
   input wire logic rx_irq_out,
   input wire logic tx_irq_out
);
   logic sel_q;
   logic [2:0] acc_q;
   wire logic fall = sel_q && !select_n_in;
   wire logic rise = !sel_q && select_n_in;
   // our own copy of the latched access, so later pin changes are ignored
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sel_q <= 1'h1;
         acc_q <= 3'h0;
      end else begin
         sel_q <= select_n_in;
         if (fall)
            acc_q <= {read_write_n_in, reg_sel_in};
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_rst;
      disable iff (1'h0) !nrst_in |-> !serial_out && !rx_irq_out
         && !tx_irq_out && host_bus_oe_n_out;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_own;
      !host_bus_oe_n_out |-> !select_n_in && acc_q[2];
   endproperty
   a_own: assert property (p_own) else $error("bus driven");
   property p_drv;
      fall && read_write_n_in ##1 !select_n_in |-> !host_bus_oe_n_out;
   endproperty
   a_drv: assert property (p_drv) else $error("bus not driven");
   property p_rdclr;
      fall && read_write_n_in && reg_sel_in == 2'h0 |=> !rx_irq_out;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("rx irq kept");
   property p_txclr;
      rise && acc_q == 3'h1 |=> !tx_irq_out;
   endproperty
   a_txclr: assert property (p_txclr) else $error("tx irq kept");
   property p_ack;
      rise && acc_q == 3'h4 |-> ##[3:56] $rose(serial_out);
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_slo;
      $rose(serial_out) && !rate_select_in |-> serial_out[*4];
   endproperty
   a_slo: assert property (p_slo) else $error("start width");
   property p_shi;
      $rose(serial_out) && rate_select_in |-> serial_out[*2] ##1 1'h1;
   endproperty
   a_shi: assert property (p_shi) else $error("fast start");
   property p_stat;
      fall && read_write_n_in && reg_sel_in[1] |=> host_bus_out[7:2] == 6'h00
         && (acc_q[0] ? tx_irq_out : rx_irq_out) == (&host_bus_out[1:0]);
   endproperty
   a_stat: assert property (p_stat) else $error("status");
   property p_inv;
      fall && read_write_n_in && reg_sel_in == 2'h1 |=> host_bus_out == 8'h00;
   endproperty
   a_inv: assert property (p_inv) else $error("bad read");
   c_tx: cover property (rise && acc_q == 3'h1);
   c_rd: cover property (rise && acc_q == 3'h4);
   c_st: cover property (fall && read_write_n_in && reg_sel_in[1]);
endmodule
bind slpa_top slpa_checker slpa_checker_inst (
   .clk_in(clk_in), .nrst_in(nrst_in), .serial_out(serial_out),
   .rate_select_in(rate_select_in), .select_n_in(select_n_in),
   .read_write_n_in(read_write_n_in), .reg_sel_in(reg_sel_in),
   .host_bus_out(host_bus_out), .host_bus_oe_n_out(host_bus_oe_n_out),
   .rx_irq_out(rx_irq_out), .tx_irq_out(tx_irq_out)
);
`default_nettype wire

//--- slpa_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// far-end link peer
module slpa_peer (
   // link
   input wire logic rate_hi_in,
   input wire logic link_in,
   output logic link_out
);
   int rx_count = 0;
   int ack_count = 0;
   int ack_gap = 3;
   logic [7:0] rx_byte = 8'h00;
   bit busy = 1'h0;
   realtime bt;
   initial link_out = 1'h0;
   always_comb bt = rate_hi_in ? 50.0 : 100.0;
   task automatic put(input logic [10:0] v, input int n);
      wait (!busy);
      busy = 1'h1;
      for (int i = 0; i < n; i++) begin
         link_out = v[i];
         #(bt);
      end
      link_out = 1'h0;
      busy = 1'h0;
   endtask
   task automatic send_byte(input logic [7:0] b);
      put({1'h0, b, 2'h3}, 11);
   endtask
   // mid-bit sampling on our own time base, blind to the host clock
   always begin
      @(posedge link_in);
      #(bt * 1.5);
      if (link_in) begin
         for (int i = 0; i < 8; i++) begin
            #(bt);
            rx_byte[i] = link_in;
         end
         rx_count++;
         fork
            begin
               #(bt * ack_gap);
               put(11'h001, 2);
            end
         join_none
      end else
         ack_count++;
   end
endmodule
`default_nettype wire

//--- test_serial_link_parallel_adaptor.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_link_parallel_adaptor;
   logic clk_in = 1'h0;
   logic nrst_in = 1'h1;
   logic rate_select_in = 1'h0;
   logic select_n_in = 1'h1;
   logic read_write_n_in = 1'h1;
   logic [1:0] reg_sel_in = 2'h0;
   logic [7:0] host_bus_in = 8'h00;
   wire serial_in, serial_out, host_bus_oe_n_out, rx_irq_out, tx_irq_out;
   wire [7:0] host_bus_out;
   int failures = 0;
   int total_checks = 0;
   int n, k;
   logic [7:0] rd, b;
   always #12.5 clk_in = ~clk_in;
   slpa_top slpa_top_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .serial_in(serial_in),
      .serial_out(serial_out), .rate_select_in(rate_select_in),
      .select_n_in(select_n_in), .read_write_n_in(read_write_n_in),
      .reg_sel_in(reg_sel_in), .host_bus_in(host_bus_in),
      .host_bus_out(host_bus_out), .host_bus_oe_n_out(host_bus_oe_n_out),
      .rx_irq_out(rx_irq_out), .tx_irq_out(tx_irq_out)
   );
   slpa_peer slpa_peer_inst (
      .rate_hi_in(rate_select_in), .link_in(serial_out), .link_out(serial_in)
   );
   task automatic chk(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (failures == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_in);
      #2;
   endtask
   // select and direction are scrambled after the fall on purpose
   task automatic acc(input logic rw, input logic [1:0] sel,
      input logic [7:0] wd);
      select_n_in = 1'h0;
      read_write_n_in = rw;
      reg_sel_in = sel;
      host_bus_in = wd;
      tick(1);
      reg_sel_in = ~sel;
      read_write_n_in = ~rw;
      tick(1);
      rd = host_bus_out;
      chk("oe_n", {7'h00, host_bus_oe_n_out}, {7'h00, ~rw});
      select_n_in = 1'h1;
      tick(2);
   endtask
   initial begin
      b = $urandom(57);
      #1;
      nrst_in = 1'h0;
      // clock runs from time zero; inputs idle in reset
      repeat (16) @(posedge clk_in);
      #2;
      rd = {4'h0, serial_out, rx_irq_out, tx_irq_out, host_bus_oe_n_out};
      chk("reset", rd, 8'h01);
      nrst_in = 1'h1;
      tick(1);
      acc(1'h1, 2'h2, 8'h00);
      chk("rx_stat", rd, 8'h00);
      acc(1'h1, 2'h3, 8'h00);
      chk("tx_stat", rd, 8'h01);
      acc(1'h0, 2'h2, 8'h02);
      acc(1'h0, 2'h3, 8'h02);
      chk("irqs", {6'h00, rx_irq_out, tx_irq_out}, 8'h01);
      acc(1'h1, 2'h1, 8'h00);
      chk("bad_rd", rd, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rate_select_in = i[0];
         slpa_peer_inst.ack_gap = $urandom_range(12, 3);
         b = (i < 2) ? {8{i[0]}} : 8'($urandom);
         k = slpa_peer_inst.rx_count;
         acc(1'h0, 2'h1, b);
         chk("tx_busy", {7'h00, tx_irq_out}, 8'h00);
         for (n = 0; slpa_peer_inst.rx_count == k && n < 300; n++)
            tick(1);
         chk("tx_byte", slpa_peer_inst.rx_byte, b);
         chk("no_ack", {7'h00, tx_irq_out}, 8'h00);
         for (n = 0; tx_irq_out !== 1'h1 && n < 300; n++)
            tick(1);
         chk("tx_done", {7'h00, tx_irq_out}, 8'h01);
         b = 8'($urandom);
         k = slpa_peer_inst.ack_count;
         #(i);
         fork
            slpa_peer_inst.send_byte(b);
         join_none
         @(posedge serial_in);
         for (n = 0; rx_irq_out !== 1'h1 && n < 60; n++)
            @(posedge clk_in);
         chk("rx_irq", {7'h00, n <= (i[0] ? 28 : 56)}, 8'h01);
         tick(1);
         acc(1'h0, 2'h0, ~b);
         chk("early_ack", 8'(slpa_peer_inst.ack_count - k), 8'h00);
         acc(1'h1, 2'h0, 8'h00);
         chk("rx_byte", rd, b);
         chk("rx_clr", {7'h00, rx_irq_out}, 8'h00);
         for (n = 0; slpa_peer_inst.ack_count == k && n < 100; n++)
            tick(1);
         chk("ack", 8'(slpa_peer_inst.ack_count - k), 8'h01);
         acc(1'h1, 2'h2, 8'h00);
         chk("rx_flag", rd, 8'h02);
      end
      acc(1'h0, 2'h3, 8'h00);
      chk("mask", {7'h00, tx_irq_out}, 8'h00);
      end_sim();
   end
   initial begin
      #100000;
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire
